// File: hdl/iptr_pkg.sv
// Constants and types shared by the indirect pointer access block
package iptr_pkg;
    localparam int APB_AW = 16;
    localparam int APB_DW = 32;
    localparam int BYTE_W = 8;
    localparam int PTR_W = 12;
    localparam int HI_W = PTR_W - BYTE_W;
    localparam int NUM_PTR = 3;
    localparam int BANK_W = 4;
    localparam int FLAGS_W = 5;
    localparam int MODE_W = 3;
    localparam int IDX_W = 2;

    // Register byte offsets
    localparam logic [APB_AW-1:0] OFS_PTR_HI_BASE = 16'h0000;
    localparam logic [APB_AW-1:0] OFS_PTR_STRIDE = 16'h000C;
    localparam logic [APB_AW-1:0] OFS_LO_DELTA = 16'h0004;
    localparam logic [APB_AW-1:0] OFS_ACCUM = 16'h0008;
    localparam logic [APB_AW-1:0] OFS_BANK = 16'h0014;
    localparam logic [APB_AW-1:0] OFS_FLAGS = 16'h0020;

    // Address decode fields
    localparam logic [7:0] REG_PAGE = 8'h00;
    localparam logic [7:0] IND_PAGE = 8'h01;
    localparam logic [1:0] MEM_WIN = 2'h1;
    localparam int IDX_LSB = 5;
    localparam int MODE_LSB = 2;
    localparam int WIN_LSB = 14;

    // Indirect access modes, one word each inside a pointer's group
    localparam logic [MODE_W-1:0] MD_PLAIN_INDIRECT_ACCESS = 3'h0;
    localparam logic [MODE_W-1:0] MD_INDIRECT_THEN_INCREMENT = 3'h1;
    localparam logic [MODE_W-1:0] MD_INDIRECT_THEN_DECREMENT = 3'h2;
    localparam logic [MODE_W-1:0] MD_INCREMENT_THEN_INDIRECT = 3'h3;
    localparam logic [MODE_W-1:0] MD_INDIRECT_OFFSET_BY_ACCUMULATOR = 3'h4;

    // Reset values and the one-step pointer increment
    localparam logic [PTR_W-1:0] RST_PTR = 12'h000;
    localparam logic [BYTE_W-1:0] RST_ACCUM = 8'h00;
    localparam logic [BANK_W-1:0] RST_BANK = 4'h0;
    localparam logic [FLAGS_W-1:0] RST_FLAGS = 5'h00;
    localparam logic [PTR_W-1:0] PTR_ONE = 12'h001;

    typedef enum logic [1:0] {K_REG, K_IND, K_MEM, K_ERR} iptr_kind_e;
    typedef enum logic [1:0] {S_IDLE, S_FETCH, S_LOAD, S_DONE} iptr_state_e;
endpackage

// File: hdl/iptr_mem.sv
// Byte-wide data memory with registered read data
`timescale 1ns/1ns
`default_nettype none
module iptr_mem #(
    parameter int AW = 12,
    parameter int DW = 8
) (
    // Clock
    input wire logic clk_i,
    // Access
    input wire logic we_i,
    input wire logic [AW-1:0] addr_i,
    input wire logic [DW-1:0] wdata_i,
    output logic [DW-1:0] rdata_o
);
    logic [DW-1:0] mem_q [0:(1<<AW)-1];
    logic [DW-1:0] rdata_q;

    always_ff @(posedge clk_i) begin
        if (we_i) begin
            mem_q[addr_i] <= wdata_i;
        end
    end

    always_ff @(posedge clk_i) begin
        rdata_q <= mem_q[addr_i];
    end

    assign rdata_o = rdata_q;
endmodule
`default_nettype wire

// File: hdl/iptr_ptr.sv
// One 12-bit data pointer with byte loads and single steps
`timescale 1ns/1ns
`default_nettype none
module iptr_ptr
    import iptr_pkg::*;
(
    // Clock and reset
    input wire logic clk_i,
    input wire logic nrst_i,
    // Byte loads
    input wire logic ld_hi_i,
    input wire logic ld_lo_i,
    input wire logic [BYTE_W-1:0] wdata_i,
    // Steps
    input wire logic step_up_i,
    input wire logic step_dn_i,
    // Value
    output logic [PTR_W-1:0] ptr_o
);
    logic [PTR_W-1:0] ptr_q;

    // Steps span all 12 bits so the low byte carries into the high nibble
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            ptr_q <= RST_PTR;
        end else if (ld_hi_i) begin
            ptr_q[PTR_W-1:BYTE_W] <= wdata_i[HI_W-1:0];
        end else if (ld_lo_i) begin
            ptr_q[BYTE_W-1:0] <= wdata_i;
        end else if (step_up_i) begin
            ptr_q <= ptr_q + PTR_ONE;
        end else if (step_dn_i) begin
            ptr_q <= ptr_q - PTR_ONE;
        end
    end

    assign ptr_o = ptr_q;
endmodule
`default_nettype wire

// File: hdl/iptr_top.sv
// Indirect data-memory pointer block with APB register access
//
// Functional notes
// - Plain indirect access uses the pointer's address and leaves the pointer unchanged.
// - Post-increment access uses the current pointer, then adds one.
// - Post-decrement access uses the current pointer, then subtracts one.
// - Pre-increment access adds one first, then uses the new value as address.
// - Offset access addresses memory at pointer plus working register.
// - Indirect locations hold nothing; accesses go to the addressed memory byte.
//
// Chosen here: the address map and the APB slave port.
`timescale 1ns/1ns
`default_nettype none
module iptr_top
    import iptr_pkg::*;
(
    // Clock and reset
    input wire logic REF_CLK_I,
    input wire logic NRST_I,
    // APB request
    input wire logic PSEL_I,
    input wire logic PENABLE_I,
    input wire logic PWRITE_I,
    input wire logic [iptr_pkg::APB_AW-1:0] PADDR_I,
    input wire logic [iptr_pkg::APB_DW-1:0] PWDATA_I,
    input wire logic [3:0] PSTRB_I,
    // APB answer
    output logic [iptr_pkg::APB_DW-1:0] PRDATA_O,
    output logic PREADY_O,
    output logic PSLVERR_O
);
    import iptr_pkg::*;

    iptr_state_e state_q;
    iptr_kind_e kind_q;
    iptr_kind_e kind_d;
    logic [APB_AW-1:0] addr_q;
    logic [IDX_W-1:0] idx_q;
    logic [MODE_W-1:0] mode_q;
    logic [APB_DW-1:0] prdata_q;
    logic pready_q;
    logic pslverr_q;
    logic [BYTE_W-1:0] accum_q;
    logic [BANK_W-1:0] bank_q;
    logic [FLAGS_W-1:0] flags_q;
    logic [PTR_W-1:0] ptr_w [0:NUM_PTR-1];
    logic [NUM_PTR-1:0] hit_hi;
    logic [NUM_PTR-1:0] hit_lo;
    logic [PTR_W-1:0] sel_ptr;
    logic [PTR_W-1:0] mem_addr;
    logic [BYTE_W-1:0] mem_rdata;
    logic [APB_DW-1:0] reg_rd;
    logic reg_hit;
    logic commit;
    logic commit_wr;
    logic mem_we;
    logic commit_ind;

    assign commit = (state_q == S_DONE) && PSEL_I && PENABLE_I;
    assign commit_wr = commit && PWRITE_I && PSTRB_I[0];
    assign commit_ind = commit && (kind_q == K_IND);

    // Decode of a new request; unused offsets in the indirect page are errors
    always_comb begin
        kind_d = K_ERR;
        if (PADDR_I[1:0] != 2'h0) begin
            kind_d = K_ERR;
        end else if (PADDR_I[APB_AW-1:WIN_LSB] == MEM_WIN) begin
            kind_d = K_MEM;
        end else if (PADDR_I[APB_AW-1:BYTE_W] == IND_PAGE && !PADDR_I[7]
                     && PADDR_I[IDX_LSB+:IDX_W] < IDX_W'(NUM_PTR)
                     && PADDR_I[MODE_LSB+:MODE_W] <= MD_INDIRECT_OFFSET_BY_ACCUMULATOR) begin
            kind_d = K_IND;
        end else if (PADDR_I[APB_AW-1:BYTE_W] == REG_PAGE) begin
            kind_d = K_REG;
        end
    end

    // Request sequencing: fetch, load answer, commit on the ready cycle
    always_ff @(posedge REF_CLK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            state_q <= S_IDLE;
        end else begin
            case (state_q)
                S_IDLE: begin
                    if (PSEL_I && PENABLE_I) begin
                        state_q <= S_FETCH;
                    end
                end
                S_FETCH: state_q <= S_LOAD;
                S_LOAD: state_q <= S_DONE;
                S_DONE: state_q <= S_IDLE;
                default: state_q <= S_IDLE;
            endcase
        end
    end

    always_ff @(posedge REF_CLK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            kind_q <= K_ERR;
            addr_q <= '0;
            idx_q <= '0;
            mode_q <= MD_PLAIN_INDIRECT_ACCESS;
        end else if (state_q == S_IDLE && PSEL_I && PENABLE_I) begin
            kind_q <= kind_d;
            addr_q <= PADDR_I;
            idx_q <= PADDR_I[IDX_LSB+:IDX_W];
            mode_q <= PADDR_I[MODE_LSB+:MODE_W];
        end
    end

    // Pointers, one per generate entry
    generate
        for (genvar i = 0; i < NUM_PTR; i++) begin : g_ptr
            localparam logic [APB_AW-1:0] OFS_HI = APB_AW'(OFS_PTR_HI_BASE + i * OFS_PTR_STRIDE);
            logic sel;
            logic up;
            logic dn;
            assign hit_hi[i] = (addr_q == OFS_HI);
            assign hit_lo[i] = (addr_q == APB_AW'(OFS_HI + OFS_LO_DELTA));
            assign sel = commit_ind && (idx_q == IDX_W'(i));
            assign up = sel && (mode_q == MD_INDIRECT_THEN_INCREMENT
                                || mode_q == MD_INCREMENT_THEN_INDIRECT);
            assign dn = sel && (mode_q == MD_INDIRECT_THEN_DECREMENT);
            iptr_ptr u_ptr (
                .clk_i(REF_CLK_I),
                .nrst_i(NRST_I),
                .ld_hi_i(commit_wr && kind_q == K_REG && hit_hi[i]),
                .ld_lo_i(commit_wr && kind_q == K_REG && hit_lo[i]),
                .wdata_i(PWDATA_I[BYTE_W-1:0]),
                .step_up_i(up),
                .step_dn_i(dn),
                .ptr_o(ptr_w[i])
            );
        end
    endgenerate

    // Memory address; plain and post modes use the pointer as it stands
    assign sel_ptr = ptr_w[idx_q];
    always_comb begin
        mem_addr = sel_ptr;
        if (kind_q == K_MEM) begin
            mem_addr = addr_q[MODE_LSB+:PTR_W];
        end else if (mode_q == MD_INCREMENT_THEN_INDIRECT) begin
            mem_addr = sel_ptr + PTR_ONE;
        end else if (mode_q == MD_INDIRECT_OFFSET_BY_ACCUMULATOR) begin
            mem_addr = sel_ptr + {{HI_W{1'b0}}, accum_q};
        end
    end

    // Indirect writes land in memory only; the locations store nothing
    assign mem_we = commit_wr && (kind_q == K_IND || kind_q == K_MEM);

    iptr_mem #(
        .AW(PTR_W),
        .DW(BYTE_W)
    ) u_mem (
        .clk_i(REF_CLK_I),
        .we_i(mem_we),
        .addr_i(mem_addr),
        .wdata_i(PWDATA_I[BYTE_W-1:0]),
        .rdata_o(mem_rdata)
    );

    // Plain register read mux; unimplemented bits read as zero
    always_comb begin
        reg_rd = '0;
        reg_hit = 1'b0;
        for (int i = 0; i < NUM_PTR; i++) begin
            if (hit_hi[i]) begin
                reg_rd = APB_DW'(ptr_w[i][PTR_W-1:BYTE_W]);
                reg_hit = 1'b1;
            end
            if (hit_lo[i]) begin
                reg_rd = APB_DW'(ptr_w[i][BYTE_W-1:0]);
                reg_hit = 1'b1;
            end
        end
        if (addr_q == OFS_ACCUM) begin
            reg_rd = APB_DW'(accum_q);
            reg_hit = 1'b1;
        end
        if (addr_q == OFS_BANK) begin
            reg_rd = APB_DW'(bank_q);
            reg_hit = 1'b1;
        end
        if (addr_q == OFS_FLAGS) begin
            reg_rd = APB_DW'(flags_q);
            reg_hit = 1'b1;
        end
    end

    // Answer: data and ready are set together; ready stands for one cycle, data holds until the next answer
    always_ff @(posedge REF_CLK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            prdata_q <= '0;
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
        end else if (state_q == S_LOAD) begin
            pready_q <= 1'b1;
            pslverr_q <= (kind_q == K_ERR) || (kind_q == K_REG && !reg_hit);
            if (kind_q == K_IND || kind_q == K_MEM) begin
                prdata_q <= APB_DW'(mem_rdata);
            end else if (kind_q == K_REG) begin
                prdata_q <= reg_rd;
            end else begin
                prdata_q <= '0;
            end
        end else begin
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
        end
    end

    always_ff @(posedge REF_CLK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            accum_q <= RST_ACCUM;
            bank_q <= RST_BANK;
            flags_q <= RST_FLAGS;
        end else if (commit_wr && kind_q == K_REG) begin
            if (addr_q == OFS_ACCUM) begin
                accum_q <= PWDATA_I[BYTE_W-1:0];
            end
            if (addr_q == OFS_BANK) begin
                bank_q <= PWDATA_I[BANK_W-1:0];
            end
            if (addr_q == OFS_FLAGS) begin
                flags_q <= PWDATA_I[FLAGS_W-1:0];
            end
        end
    end

    assign PRDATA_O = prdata_q;
    assign PREADY_O = pready_q;
    assign PSLVERR_O = pslverr_q;

    default clocking cb @(posedge REF_CLK_I); endclocking
    default disable iff (!NRST_I);

    a_plain_ptr_kept: assert property (
        commit_ind && mode_q == MD_PLAIN_INDIRECT_ACCESS
        |=> ptr_w[idx_q] == $past(ptr_w[idx_q]))
        else $error("plain access changed the pointer");

    a_postinc_step: assert property (
        commit_ind && mode_q == MD_INDIRECT_THEN_INCREMENT
        |=> ptr_w[idx_q] == PTR_W'($past(ptr_w[idx_q]) + PTR_ONE))
        else $error("post-increment did not add one");

    a_postdec_step: assert property (
        commit_ind && mode_q == MD_INDIRECT_THEN_DECREMENT
        |=> ptr_w[idx_q] == PTR_W'($past(ptr_w[idx_q]) - PTR_ONE))
        else $error("post-decrement did not subtract one");

    // Ties the used address to the stepped pointer, so a wrong address cannot hide
    a_post_addr_current: assert property (
        commit_ind
        && (mode_q == MD_INDIRECT_THEN_INCREMENT || mode_q == MD_INDIRECT_THEN_DECREMENT)
        |=> ptr_w[idx_q] == (mode_q == MD_INDIRECT_THEN_INCREMENT
                             ? PTR_W'($past(mem_addr) + PTR_ONE)
                             : PTR_W'($past(mem_addr) - PTR_ONE)))
        else $error("post access did not use the current pointer");

    a_preinc_addr: assert property (
        state_q == S_FETCH && kind_q == K_IND && mode_q == MD_INCREMENT_THEN_INDIRECT
        && PSEL_I && PENABLE_I
        |-> mem_addr == PTR_W'(sel_ptr + PTR_ONE) ##3 ptr_w[idx_q] == $past(mem_addr, 3))
        else $error("pre-increment address or update wrong");

    a_offset_addr: assert property (
        state_q != S_IDLE && kind_q == K_IND && mode_q == MD_INDIRECT_OFFSET_BY_ACCUMULATOR
        |-> mem_addr == PTR_W'(sel_ptr + {{HI_W{1'b0}}, accum_q}))
        else $error("offset address is not pointer plus accumulator");

    a_offset_ptr_kept: assert property (
        commit_ind && mode_q == MD_INDIRECT_OFFSET_BY_ACCUMULATOR
        |=> ptr_w[idx_q] == $past(ptr_w[idx_q]))
        else $error("offset access changed the pointer");

    a_ind_read_data: assert property (
        state_q == S_LOAD && kind_q == K_IND
        |=> PREADY_O && PRDATA_O == APB_DW'($past(mem_rdata)))
        else $error("indirect read did not return the memory byte");

    a_carry_across: assert property (
        commit_ind && mode_q == MD_INDIRECT_THEN_INCREMENT && sel_ptr[BYTE_W-1:0] == 8'hFF
        |=> ptr_w[idx_q][BYTE_W-1:0] == 8'h00
        && ptr_w[idx_q][PTR_W-1:BYTE_W] == HI_W'($past(sel_ptr[PTR_W-1:BYTE_W]) + 1'b1))
        else $error("increment did not carry into the high nibble");

    a_ready_one_cycle: assert property (PREADY_O |=> !PREADY_O)
        else $error("ready stood longer than one cycle");

    a_refused_no_data: assert property (PREADY_O && PSLVERR_O |-> PRDATA_O == '0)
        else $error("refused transfer returned data");

    a_ind_no_reg_write: assert property (
        commit_ind |=> $stable(accum_q) && $stable(bank_q) && $stable(flags_q))
        else $error("indirect access changed a plain register");

    c_preinc_read: cover property (commit_ind && !PWRITE_I
        && mode_q == MD_INCREMENT_THEN_INDIRECT);
    c_postdec_write: cover property (commit_ind && PWRITE_I
        && mode_q == MD_INDIRECT_THEN_DECREMENT);
    c_offset_access: cover property (commit_ind
        && mode_q == MD_INDIRECT_OFFSET_BY_ACCUMULATOR);
    c_unmapped_error: cover property (PREADY_O && PSLVERR_O);
endmodule
`default_nettype wire

// File: bench/indirect_pointer_access_tb.sv
// Self-checking bench for the indirect pointer access block
`timescale 1ns/1ns
`default_nettype none
module indirect_pointer_access_tb;
    import iptr_pkg::*;
    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [APB_AW-1:0] paddr = '0;
    logic [APB_DW-1:0] pwdata = '0;
    logic [3:0] pstrb = 4'hF;
    logic [APB_DW-1:0] prdata;
    logic pready;
    logic pslverr;
    // Each note is {check data, expect error, expected byte}
    logic [9:0] notes[$];
    logic [9:0] nt;
    logic [7:0] ref_mem [0:4095];
    logic [PTR_W-1:0] ref_ptr [0:2];
    logic [7:0] ref_w;
    logic [7:0] d;
    logic [11:0] v;
    int fails = 0;
    int n_compared = 0;
    int unsigned seed;

    iptr_top u_dut (
        .REF_CLK_I(clk),
        .NRST_I(nrst),
        .PSEL_I(psel),
        .PENABLE_I(penable),
        .PWRITE_I(pwrite),
        .PADDR_I(paddr),
        .PWDATA_I(pwdata),
        .PSTRB_I(pstrb),
        .PRDATA_O(prdata),
        .PREADY_O(pready),
        .PSLVERR_O(pslverr)
    );

    always #25 clk = ~clk;

    task automatic stop_test();
        $display("Compared %0d, mismatches %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    // Answers are matched in order, so a dropped or extra answer shows up at once
    always @(posedge clk) begin
        if (pready === 1'b1) begin
            nt = notes.pop_front();
            n_compared++;
            if (pslverr !== nt[8] || (nt[9] && prdata !== {24'h0, nt[7:0]})) begin
                fails++;
                $display("[ERR] %0t addr %h got %h err %b", $time, paddr, prdata, pslverr);
            end
        end
    end

    task automatic apb(input logic wr, input logic [15:0] a, input logic [7:0] dd,
                       input logic [3:0] st, input logic chk, input logic err,
                       input logic [7:0] exp);
        int n;
        notes.push_back({chk, err, exp});
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        // Upper lanes carry noise that the block must ignore
        pwdata <= {24'($urandom), dd};
        pstrb <= st;
        @(posedge clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n >= 20) begin
            fails++;
            $display("[ERR] %0t no answer at %h", $time, a);
        end
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr_reg(input logic [15:0] a, input logic [7:0] dd);
        apb(1'b1, a, dd, 4'hF, 1'b0, 1'b0, 8'h00);
    endtask

    task automatic rd_chk(input logic [15:0] a, input logic [7:0] exp);
        apb(1'b0, a, 8'h00, 4'hF, 1'b1, 1'b0, exp);
    endtask

    task automatic refused(input logic wr, input logic [15:0] a);
        apb(wr, a, 8'h5A, 4'hF, 1'b1, 1'b1, 8'h00);
    endtask

    function automatic logic [7:0] reg_mask(input int i);
        if (i == 8) return 8'h1F;
        if (i % 3 == 0 || i == 5) return 8'h0F;
        return 8'hFF;
    endfunction

    task automatic set_ptr(input int n, input logic [11:0] pv);
        wr_reg(16'(12 * n), {4'h0, pv[11:8]});
        wr_reg(16'(12 * n + 4), pv[7:0]);
        ref_ptr[n] = pv;
    endtask

    task automatic chk_ptr(input int n);
        rd_chk(16'(12 * n), {4'h0, ref_ptr[n][11:8]});
        rd_chk(16'(12 * n + 4), ref_ptr[n][7:0]);
    endtask

    task automatic ind(input int n, input int md, input logic wr, input logic [7:0] dd);
        logic [11:0] a;
        a = (md == 3) ? ref_ptr[n] + 12'h001 : ref_ptr[n];
        if (md == 4) a = ref_ptr[n] + {4'h0, ref_w};
        apb(wr, 16'(32'h100 + 32 * n + 4 * md), dd, 4'hF, !wr, 1'b0, ref_mem[a]);
        if (wr) ref_mem[a] = dd;
        if (md == 1 || md == 3) ref_ptr[n] = ref_ptr[n] + 12'h001;
        if (md == 2) ref_ptr[n] = ref_ptr[n] - 12'h001;
        if (wr) rd_chk(16'(32'h4000 + 4 * a), dd);
    endtask

    initial begin
        repeat (60000) @(posedge clk);
        fails++;
        $display("[ERR] %0t watchdog expired", $time);
        stop_test();
    end

    initial begin
        seed = $urandom(10);
        repeat (5) @(posedge clk);
        nrst <= 1'b1;
        for (int i = 0; i < 9; i++) rd_chk(16'(4 * i), 8'h00);
        for (int i = 0; i < 9; i++) begin
            d = 8'($urandom);
            wr_reg(16'(4 * i), d);
            rd_chk(16'(4 * i), d & reg_mask(i));
        end
        wr_reg(16'h0008, 8'h3C);
        apb(1'b1, 16'h0008, 8'hC3, 4'h0, 1'b0, 1'b0, 8'h00);
        rd_chk(16'h0008, 8'h3C);
        for (int i = 0; i < 4096; i++) begin
            ref_mem[i] = 8'($urandom);
            wr_reg(16'(32'h4000 + 4 * i), ref_mem[i]);
        end
        // Refused transfers must leave the pointer alone
        set_ptr(0, 12'h123);
        refused(1'b0, 16'h0002);
        refused(1'b1, 16'h0024);
        refused(1'b1, 16'h0114);
        refused(1'b0, 16'h0160);
        refused(1'b1, 16'h0200);
        refused(1'b0, 16'h0180);
        chk_ptr(0);
        for (int n = 0; n < 3; n++) begin
            for (int md = 0; md < 5; md++) begin
                for (int k = 0; k < 4; k++) begin
                    v = (k == 0) ? 12'h0FF : (k == 1) ? 12'h100 : (k == 2) ? 12'hFFF
                        : 12'($urandom);
                    set_ptr(n, v);
                    ref_w = 8'($urandom);
                    wr_reg(16'h0008, ref_w);
                    ind(n, md, 1'($urandom), 8'($urandom));
                    ind(n, md, 1'b0, 8'h00);
                    chk_ptr(n);
                end
            end
        end
        // Reset in mid-run clears every register once more
        nrst <= 1'b0;
        repeat (2) @(posedge clk);
        nrst <= 1'b1;
        for (int i = 0; i < 9; i++) rd_chk(16'(4 * i), 8'h00);
        repeat (3) @(posedge clk);
        if (notes.size() != 0) begin
            fails++;
            $display("[ERR] %0t %0d answers missing", $time, notes.size());
        end
        stop_test();
    end
endmodule
`default_nettype wire
